/* File: rsp_defs.svh */
// Constants of the ramp stall supervisor: offsets, resets, limits, timing
`ifndef RSP_DEFS_SVH
`define RSP_DEFS_SVH
//--------------------------------------------------------------
// Register offsets
//--------------------------------------------------------------
`define RSP_A_ACC_SEL 4'h0
`define RSP_A_ACC_LVL 4'h1
`define RSP_A_FLOOR 4'h2
`define RSP_A_DEC_SEL 4'h3
`define RSP_A_COF 4'h4
`define RSP_A_INV 4'h5
`define RSP_A_DRV 4'h6
`define RSP_A_STATUS 4'h7
//--------------------------------------------------------------
// Reset values
//--------------------------------------------------------------
`define RSP_RST_ACC_SEL 2'h1
`define RSP_RST_ACC_LVL 8'h96
`define RSP_RST_FLOOR 8'h32
`define RSP_RST_DEC_SEL 2'h1
`define RSP_RST_COF 16'h1770
`define RSP_RST_INV 10'h190
//--------------------------------------------------------------
// Setting ranges
//--------------------------------------------------------------
`define RSP_MAX_ACC_SEL 2'h2
`define RSP_MAX_ACC_LVL 8'hC8
`define RSP_MAX_FLOOR 8'h64
`define RSP_MAX_DEC_SEL 2'h3
`define RSP_MAX_DEC_SEL_VEC 2'h2
//--------------------------------------------------------------
// Bus voltage stall levels in volts
//--------------------------------------------------------------
`define RSP_V_200 10'h17C
`define RSP_V_400_HI 10'h2F8
`define RSP_V_400_LO 10'h294
`define RSP_INV_SPLIT 10'h190
`define RSP_NEAR_V 10'h00A
//--------------------------------------------------------------
// Rates and percent scaling
//--------------------------------------------------------------
`define RSP_SLOW_PCT 8'h55
`define RSP_PCT_DEN 16'h0064
`define RSP_RATE_FULL 8'hFF
`define RSP_RATE_HALF 8'h80
`define RSP_RATE_ZERO 8'h00
`define RSP_RATE_STEP 8'h01
//--------------------------------------------------------------
// Timing
//--------------------------------------------------------------
`define RSP_CLK_NS 10
`define RSP_TICK_NS 1000
`endif

/* File: rsp_pkg.sv */
// Types of the ramp stall supervisor
package rsp_pkg;
   typedef enum logic [2:0] {
      RSP_M_VF = 3'h0,
      RSP_M_VFPG = 3'h1,
      RSP_M_OLV1 = 3'h2,
      RSP_M_FLUX = 3'h3,
      RSP_M_OLV2 = 3'h4
   } rsp_method_t;
   typedef enum logic [2:0] {
      RSP_ACC_FREE = 3'b001,
      RSP_ACC_SLOW = 3'b010,
      RSP_ACC_HOLD = 3'b100
   } rsp_acc_st_t;
   typedef enum logic [1:0] {
      RSP_DEC_FREE = 2'b01,
      RSP_DEC_HOLD = 2'b10
   } rsp_dec_st_t;
   typedef struct packed {
      logic [1:0] acc_sel;
      logic [7:0] acc_lvl;
      logic [7:0] floor_lvl;
      logic [1:0] dec_sel;
      logic [15:0] cof;
      logic [9:0] inv;
      logic [2:0] method;
      logic class400;
   } rsp_cfg_t;
   typedef struct packed {
      logic [11:0] spare;
      logic class400;
      logic [2:0] method;
   } rsp_drv_t;
   typedef struct packed {
      logic [7:0] eff_lvl;
      logic spare;
      logic rate_auto;
      logic [1:0] dec_st;
      logic [2:0] acc_st;
      logic reject;
   } rsp_stat_t;
endpackage

/* File: rsp_div.sv */
// Iterative unsigned divider used to scale the stall level
`timescale 1ns/1ps
module rsp_div
   import rsp_pkg::*;
#(
   parameter int NW = 24,
   parameter int DW = 16
)(
   input wire logic core_clk,
   input wire logic rst,
   input wire logic start,
   input wire logic [NW-1:0] num,
   input wire logic [DW-1:0] den,
   output logic busy,
   output logic done,
   output logic [NW-1:0] quo
);
   localparam int CW = $clog2(NW + 1);
   logic [CW-1:0] cnt_reg;
   logic [NW-1:0] work_reg;
   logic [DW:0] rem_reg;
   logic [DW-1:0] den_reg;
   logic [DW:0] trial;

   assign trial = {rem_reg[DW-1:0], work_reg[NW-1]} - {1'b0, den_reg};

   always_ff @(posedge core_clk) begin
      if (rst) begin
         busy <= 1'b0;
         done <= 1'b0;
         cnt_reg <= '0;
         work_reg <= '0;
         rem_reg <= '0;
         den_reg <= '0;
      end else begin
         done <= 1'b0;
         if (!busy && start) begin
            busy <= 1'b1;
            cnt_reg <= CW'(NW);
            work_reg <= num;
            rem_reg <= '0;
            den_reg <= den;
         end else if (busy) begin
            // Restoring step: one quotient bit per cycle
            if (!trial[DW]) begin
               rem_reg <= trial;
               work_reg <= {work_reg[NW-2:0], 1'b1};
            end else begin
               rem_reg <= {rem_reg[DW-1:0], work_reg[NW-1]};
               work_reg <= {work_reg[NW-2:0], 1'b0};
            end
            cnt_reg <= cnt_reg - 1'b1;
            if (cnt_reg == CW'(1)) begin
               busy <= 1'b0;
               done <= 1'b1;
            end
         end
      end
   end

   // Zero divisor saturates, which the caller clamps anyway
   always_ff @(posedge core_clk) begin
      if (rst) begin
         quo <= '0;
      end else if (busy && cnt_reg == CW'(1)) begin
         if (den_reg == '0) begin
            quo <= '1;
         end else if (!trial[DW]) begin
            quo <= {work_reg[NW-2:0], 1'b1};
         end else begin
            quo <= {work_reg[NW-2:0], 1'b0};
         end
      end
   end
endmodule

/* File: rsp_ramp_stall.sv */
// Ramp stall supervisor: current and bus voltage limits on the ramp
//
// What this block does
// - Accel select 0: programmed rate, no current intervention.
// - Accel select 1: freeze rising ramp while current exceeds stall level.
// - Accel select 2: automatic accel rate regulated on stall level.
// - Accel select takes 0..2, default 1, only in V/f, V/f-PG, OLV1.
// - Accel stall level is percent of rated current, 0..200, default 150.
// - Floor level 0..100 percent, default 50, above constant-output start.
// - Level reduced in constant-output range, never below floor.
// - Decel select 0: programmed rate, no bus voltage intervention.
// - Decel select 1 or 2: hold falling ramp near bus stall level.
// - After hold, select 1 resumes set rate, select 2 adapts rate.
// - Decel select 3 is an enabled mode for a braking resistor unit.
// - Decel select 0..3 default 1; 0..2 in flux and OLV2 control.
// - Flux vector and OLV2 ignore the decel select entirely.
// - Bus level 380 V, or 760/660 V in 400 V class by input setting.
// - Accel select 1 slows the rate above 85 percent of stall level.
//
// The placing of the registers and the strobed register port were chosen for this implementation.
`timescale 1ns/1ps
`include "rsp_defs.svh"
module rsp_ramp_stall
   import rsp_pkg::*;
#(
   parameter int TICK_NS = `RSP_TICK_NS,
   parameter logic [9:0] NEAR_V = `RSP_NEAR_V
)(
   input wire logic core_clk,
   input wire logic rst,
   input wire logic [3:0] reg_addr,
   input wire logic [15:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [15:0] reg_rdata,
   input wire logic running,
   input wire logic accel_active,
   input wire logic decel_active,
   input wire logic [15:0] out_freq,
   input wire logic [8:0] out_current,
   input wire logic [9:0] bus_volt,
   output logic [7:0] ramp_rate,
   output logic rate_auto,
   output logic accel_hold,
   output logic decel_hold
);
   localparam int TICK_CYC = (TICK_NS + `RSP_CLK_NS - 1) / `RSP_CLK_NS;

   //-----------------------------------------------------------
   // Helpers
   //-----------------------------------------------------------
   function automatic logic vec_method(input logic [2:0] m);
      return (m == RSP_M_FLUX) || (m == RSP_M_OLV2);
   endfunction

   function automatic logic acc_method(input logic [2:0] m);
      return (m == RSP_M_VF) || (m == RSP_M_VFPG) || (m == RSP_M_OLV1);
   endfunction

   rsp_cfg_t cfg_reg, cfg_next;
   rsp_drv_t drv_w;
   rsp_stat_t stat_w;
   rsp_acc_st_t acc_st_reg, acc_st_next;
   rsp_dec_st_t dec_st_reg, dec_st_next;
   logic wr_bad;
   logic reject_reg;
   logic [7:0] acc_auto_reg, dec_auto_reg;
   logic [7:0] rate_next;
   logic rate_auto_next;
   logic [15:0] tick_cnt_reg;
   logic tick;
   logic div_busy;
   logic [23:0] div_quo;
   logic [7:0] quo_clip, eff_lvl, slow_lvl;
   logic [15:0] slow_prod;
   logic [9:0] dec_thr, dec_lim;
   logic acc_en, acc_m1, acc_m2;
   logic dec_en, dec_m2, dec_near;
   logic cur_over, cur_slow;

   assign drv_w = rsp_drv_t'(reg_wdata);

   //-----------------------------------------------------------
   // Setting writes with range and run-state checks
   //-----------------------------------------------------------
   always_comb begin
      cfg_next = cfg_reg;
      wr_bad = 1'b0;
      if (reg_wr) begin
         unique case (reg_addr)
            `RSP_A_ACC_SEL: begin
               if (running || reg_wdata > 16'(`RSP_MAX_ACC_SEL)) begin
                  wr_bad = 1'b1;
               end else begin
                  cfg_next.acc_sel = reg_wdata[1:0];
               end
            end
            `RSP_A_ACC_LVL: begin
               if (running || reg_wdata > 16'(`RSP_MAX_ACC_LVL)) begin
                  wr_bad = 1'b1;
               end else begin
                  cfg_next.acc_lvl = reg_wdata[7:0];
               end
            end
            `RSP_A_FLOOR: begin
               if (running || reg_wdata > 16'(`RSP_MAX_FLOOR)) begin
                  wr_bad = 1'b1;
               end else begin
                  cfg_next.floor_lvl = reg_wdata[7:0];
               end
            end
            `RSP_A_DEC_SEL: begin
               if (running || reg_wdata > 16'(`RSP_MAX_DEC_SEL) ||
                   (vec_method(cfg_reg.method) &&
                    reg_wdata > 16'(`RSP_MAX_DEC_SEL_VEC))) begin
                  wr_bad = 1'b1;
               end else begin
                  cfg_next.dec_sel = reg_wdata[1:0];
               end
            end
            `RSP_A_COF: begin
               if (running) begin
                  wr_bad = 1'b1;
               end else begin
                  cfg_next.cof = reg_wdata;
               end
            end
            `RSP_A_INV: begin
               if (running || |reg_wdata[15:10]) begin
                  wr_bad = 1'b1;
               end else begin
                  cfg_next.inv = reg_wdata[9:0];
               end
            end
            `RSP_A_DRV: begin
               // A vector method cannot coexist with decel select 3
               if (running || drv_w.method > RSP_M_OLV2 ||
                   (vec_method(drv_w.method) &&
                    cfg_reg.dec_sel > `RSP_MAX_DEC_SEL_VEC)) begin
                  wr_bad = 1'b1;
               end else begin
                  cfg_next.method = drv_w.method;
                  cfg_next.class400 = drv_w.class400;
               end
            end
            default: begin
               wr_bad = 1'b0;
            end
         endcase
      end
   end

   always_ff @(posedge core_clk) begin
      if (rst) begin
         cfg_reg.acc_sel <= `RSP_RST_ACC_SEL;
         cfg_reg.acc_lvl <= `RSP_RST_ACC_LVL;
         cfg_reg.floor_lvl <= `RSP_RST_FLOOR;
         cfg_reg.dec_sel <= `RSP_RST_DEC_SEL;
         cfg_reg.cof <= `RSP_RST_COF;
         cfg_reg.inv <= `RSP_RST_INV;
         cfg_reg.method <= RSP_M_VF;
         cfg_reg.class400 <= 1'b0;
      end else begin
         cfg_reg <= cfg_next;
      end
   end

   // Sticky reject flag; a new reject beats the clearing read
   always_ff @(posedge core_clk) begin
      if (rst) begin
         reject_reg <= 1'b0;
      end else if (wr_bad) begin
         reject_reg <= 1'b1;
      end else if (reg_rd && reg_addr == `RSP_A_STATUS) begin
         reject_reg <= 1'b0;
      end
   end

   //-----------------------------------------------------------
   // Read port
   //-----------------------------------------------------------
   always_comb begin
      stat_w = '0;
      stat_w.eff_lvl = eff_lvl;
      stat_w.rate_auto = rate_auto;
      stat_w.dec_st = dec_st_reg;
      stat_w.acc_st = acc_st_reg;
      stat_w.reject = reject_reg;
   end

   always_ff @(posedge core_clk) begin
      if (rst) begin
         reg_rdata <= '0;
      end else if (reg_rd) begin
         unique case (reg_addr)
            `RSP_A_ACC_SEL: reg_rdata <= 16'(cfg_reg.acc_sel);
            `RSP_A_ACC_LVL: reg_rdata <= 16'(cfg_reg.acc_lvl);
            `RSP_A_FLOOR: reg_rdata <= 16'(cfg_reg.floor_lvl);
            `RSP_A_DEC_SEL: reg_rdata <= 16'(cfg_reg.dec_sel);
            `RSP_A_COF: reg_rdata <= cfg_reg.cof;
            `RSP_A_INV: reg_rdata <= 16'(cfg_reg.inv);
            `RSP_A_DRV: reg_rdata <= {12'h000, cfg_reg.class400, cfg_reg.method};
            `RSP_A_STATUS: reg_rdata <= stat_w;
            default: reg_rdata <= 16'h0000;
         endcase
      end else begin
         reg_rdata <= 16'h0000;
      end
   end

   //-----------------------------------------------------------
   // Effective accel stall level
   //-----------------------------------------------------------
   // Level scales as start frequency over output frequency; the
   // quotient may lag a frequency change by up to two divides
   rsp_div #(.NW(24), .DW(16)) u_div (
      .core_clk(core_clk),
      .rst(rst),
      .start(!div_busy),
      .num(24'(cfg_reg.acc_lvl) * 24'(cfg_reg.cof)),
      .den(out_freq),
      .busy(div_busy),
      .done(),
      .quo(div_quo)
   );

   assign quo_clip = (div_quo > 24'(cfg_reg.acc_lvl)) ? cfg_reg.acc_lvl : div_quo[7:0];
   always_comb begin
      if (out_freq <= cfg_reg.cof) begin
         eff_lvl = cfg_reg.acc_lvl;
      end else if (quo_clip < cfg_reg.floor_lvl) begin
         eff_lvl = cfg_reg.floor_lvl;
      end else begin
         eff_lvl = quo_clip;
      end
   end

   assign slow_prod = (16'(eff_lvl) * 16'(`RSP_SLOW_PCT)) / `RSP_PCT_DEN;
   assign slow_lvl = slow_prod[7:0];
   assign cur_over = out_current > {1'b0, eff_lvl};
   assign cur_slow = out_current > {1'b0, slow_lvl};

   //-----------------------------------------------------------
   // Bus voltage level
   //-----------------------------------------------------------
   always_comb begin
      if (!cfg_reg.class400) begin
         dec_thr = `RSP_V_200;
      end else if (cfg_reg.inv >= `RSP_INV_SPLIT) begin
         dec_thr = `RSP_V_400_HI;
      end else begin
         dec_thr = `RSP_V_400_LO;
      end
   end
   // Braking resistor absorbs energy, so select 3 may run to the level
   assign dec_lim = (cfg_reg.dec_sel == `RSP_MAX_DEC_SEL) ? dec_thr : dec_thr - NEAR_V;
   assign dec_near = bus_volt >= dec_lim;

   //-----------------------------------------------------------
   // Mode decode
   //-----------------------------------------------------------
   assign acc_en = accel_active && acc_method(cfg_reg.method);
   assign acc_m1 = acc_en && cfg_reg.acc_sel == 2'h1;
   assign acc_m2 = acc_en && cfg_reg.acc_sel == `RSP_MAX_ACC_SEL;
   assign dec_en = decel_active && !vec_method(cfg_reg.method) && cfg_reg.dec_sel != 2'h0;
   assign dec_m2 = dec_en && cfg_reg.dec_sel == 2'h2;

   //-----------------------------------------------------------
   // Supervisor states
   //-----------------------------------------------------------
   always_comb begin
      acc_st_next = RSP_ACC_FREE;
      if (acc_m1 && cur_over) begin
         acc_st_next = RSP_ACC_HOLD;
      end else if (acc_m1 && cur_slow) begin
         acc_st_next = RSP_ACC_SLOW;
      end
   end

   always_comb begin
      dec_st_next = RSP_DEC_FREE;
      if (dec_en && dec_near) begin
         dec_st_next = RSP_DEC_HOLD;
      end
   end

   always_ff @(posedge core_clk) begin
      if (rst) begin
         acc_st_reg <= RSP_ACC_FREE;
         dec_st_reg <= RSP_DEC_FREE;
      end else begin
         acc_st_reg <= acc_st_next;
         dec_st_reg <= dec_st_next;
      end
   end

   //-----------------------------------------------------------
   // Adaptive rates on the slow tick
   //-----------------------------------------------------------
   always_ff @(posedge core_clk) begin
      if (rst || tick_cnt_reg == 16'(TICK_CYC - 1)) begin
         tick_cnt_reg <= '0;
      end else begin
         tick_cnt_reg <= tick_cnt_reg + 16'h0001;
      end
   end
   assign tick = tick_cnt_reg == 16'(TICK_CYC - 1);

   always_ff @(posedge core_clk) begin
      if (rst) begin
         acc_auto_reg <= `RSP_RATE_FULL;
      end else if (tick && acc_m2) begin
         if (!(out_current < {1'b0, eff_lvl})) begin
            if (acc_auto_reg != `RSP_RATE_ZERO) acc_auto_reg <= acc_auto_reg - `RSP_RATE_STEP;
         end else if (acc_auto_reg != `RSP_RATE_FULL) begin
            acc_auto_reg <= acc_auto_reg + `RSP_RATE_STEP;
         end
      end
   end

   always_ff @(posedge core_clk) begin
      if (rst) begin
         dec_auto_reg <= `RSP_RATE_FULL;
      end else if (tick && dec_m2) begin
         if (dec_near) begin
            if (dec_auto_reg != `RSP_RATE_ZERO) dec_auto_reg <= dec_auto_reg - `RSP_RATE_STEP;
         end else if (dec_auto_reg != `RSP_RATE_FULL) begin
            dec_auto_reg <= dec_auto_reg + `RSP_RATE_STEP;
         end
      end
   end

   //-----------------------------------------------------------
   // Ramp rate grant
   //-----------------------------------------------------------
   always_comb begin
      rate_next = `RSP_RATE_FULL;
      rate_auto_next = 1'b0;
      if (acc_m2) begin
         rate_next = acc_auto_reg;
         rate_auto_next = 1'b1;
      end else if (acc_st_next == RSP_ACC_HOLD) begin
         rate_next = `RSP_RATE_ZERO;
      end else if (acc_st_next == RSP_ACC_SLOW) begin
         rate_next = `RSP_RATE_HALF;
      end else if (dec_st_next == RSP_DEC_HOLD) begin
         rate_next = `RSP_RATE_ZERO;
         rate_auto_next = dec_m2;
      end else if (dec_m2) begin
         rate_next = dec_auto_reg;
         rate_auto_next = 1'b1;
      end
   end

   always_ff @(posedge core_clk) begin
      if (rst) begin
         ramp_rate <= `RSP_RATE_FULL;
         rate_auto <= 1'b0;
      end else begin
         ramp_rate <= rate_next;
         rate_auto <= rate_auto_next;
      end
   end

   assign accel_hold = acc_st_reg == RSP_ACC_HOLD;
   assign decel_hold = dec_st_reg == RSP_DEC_HOLD;

   //-----------------------------------------------------------
   // Checks
   //-----------------------------------------------------------
   acc_off_a: assert property (@(posedge core_clk) disable iff (rst)
      (accel_active && !decel_active && cfg_reg.acc_sel == 2'h0) |=> ramp_rate == 8'hFF)
      else $error("accel select 0 changed the rate");
   acc_hold_a: assert property (@(posedge core_clk) disable iff (rst)
      (acc_m1 && cur_over) |=> (ramp_rate == 8'h00 && accel_hold))
      else $error("accel ramp not frozen above level");
   acc_auto_a: assert property (@(posedge core_clk) disable iff (rst)
      acc_m2 |=> (rate_auto && ramp_rate == $past(acc_auto_reg)))
      else $error("accel auto rate not applied");
   acc_range_a: assert property (@(posedge core_clk) disable iff (rst)
      cfg_reg.acc_sel <= 2'h2 && cfg_reg.acc_lvl <= 8'hC8 && cfg_reg.floor_lvl <= 8'h64)
      else $error("setting out of range");
   eff_floor_a: assert property (@(posedge core_clk) disable iff (rst)
      (out_freq > cfg_reg.cof) |-> (eff_lvl >= cfg_reg.floor_lvl &&
      (eff_lvl <= cfg_reg.acc_lvl || eff_lvl == cfg_reg.floor_lvl)))
      else $error("effective level outside floor and level");
   dec_off_a: assert property (@(posedge core_clk) disable iff (rst)
      (decel_active && !accel_active && vec_method(cfg_reg.method)) |=> ramp_rate == 8'hFF)
      else $error("decel supervision active in vector method");
   dec_hold_a: assert property (@(posedge core_clk) disable iff (rst)
      (dec_en && !acc_en && bus_volt >= dec_lim) |=> (ramp_rate == 8'h00 && decel_hold))
      else $error("decel ramp not held near bus level");
   dec_thr_a: assert property (@(posedge core_clk) disable iff (rst)
      dec_thr == (!cfg_reg.class400 ? 10'd380 : (cfg_reg.inv >= 10'd400 ? 10'd760 : 10'd660)))
      else $error("bus stall level wrong for class");
   slow_a: assert property (@(posedge core_clk) disable iff (rst)
      (acc_m1 && !cur_over && cur_slow) |=> ramp_rate == 8'h80)
      else $error("accel rate not slowed near level");
   run_lock_a: assert property (@(posedge core_clk) disable iff (rst)
      (reg_wr && running && reg_addr <= `RSP_A_DRV) |=> ($stable(cfg_reg) && reject_reg))
      else $error("setting changed while running");
endmodule

/* File: rsp_meas.sv */
// Model of the current and bus voltage measurement path
`timescale 1ns/1ps
module rsp_meas (
   input wire logic core_clk,
   input wire logic [8:0] cur_set,
   input wire logic [9:0] volt_set,
   output logic [8:0] out_current,
   output logic [9:0] bus_volt
);
   // One sample of lag, as a real converter adds
   always_ff @(posedge core_clk) begin
      out_current <= cur_set;
      bus_volt <= volt_set;
   end
endmodule

/* File: rsp_ramp_stall_bench.sv */
// Self-checking bench of the ramp stall supervisor
`timescale 1ns/1ps
module rsp_ramp_stall_bench import rsp_pkg::*;;
   logic core_clk = 0, rst = 1, reg_wr = 0, reg_rd = 0, running = 0;
   logic accel_active = 0, decel_active = 0, rate_auto, accel_hold, decel_hold;
   logic [3:0] reg_addr = 4'h0;
   logic [15:0] reg_wdata = 16'h0000, out_freq = 16'h0000, reg_rdata, v;
   logic [8:0] cur = 9'h000, out_current;
   logic [9:0] volt = 10'h000, bus_volt;
   logic [7:0] ramp_rate;
   logic [15:0] rv [6] = '{16'h0001, 16'h0096, 16'h0032, 16'h0001, 16'h1770, 16'h0190};
   int corner [4] = '{150, 151, 127, 128};
   int t [11][5] = '{'{1, 0, 400, 369, 0}, '{1, 0, 400, 370, 1}, '{0, 0, 400, 400, 0},
      '{3, 0, 400, 379, 0}, '{3, 0, 400, 380, 1}, '{2, 0, 400, 370, 1}, '{1, 3, 400, 380, 0},
      '{1, 8, 400, 749, 0}, '{1, 8, 400, 750, 1}, '{1, 8, 399, 649, 0}, '{1, 8, 399, 650, 1}};
   int fails = 0, cmp_count = 0, c;
   always #5 core_clk = ~core_clk;
   rsp_meas meas (.core_clk, .cur_set(cur), .volt_set(volt), .out_current, .bus_volt);
   rsp_ramp_stall #(.TICK_NS(20)) uut (.core_clk, .rst, .reg_addr, .reg_wdata, .reg_wr,
      .reg_rd, .reg_rdata, .running, .accel_active, .decel_active, .out_freq, .out_current,
      .bus_volt, .ramp_rate, .rate_auto, .accel_hold, .decel_hold);
   //------------------------------------------------------------
   // Tasks and expectations
   //------------------------------------------------------------
   task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         fails++;
         $display("unexpected at %0t: saw %h, want %h", $time, seen, exp);
      end
   endtask
   task automatic wr(input logic [3:0] a, input logic [15:0] d);
      @(posedge core_clk);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge core_clk);
      reg_wr <= 1'b0;
   endtask
   task automatic rd(input logic [3:0] a);
      @(posedge core_clk);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge core_clk);
      reg_rd <= 1'b0;
      // Data stand in the cycle after the strobe; taken at its closing edge
      @(posedge core_clk);
      v = reg_rdata;
   endtask
   // Running only while measuring, since settings are refused during a run
   task automatic drive(input int cc, input int b);
      @(posedge core_clk);
      running <= 1'b1;
      cur <= 9'(cc);
      volt <= 10'(b);
      repeat (3) @(posedge core_clk);
      running <= 1'b0;
   endtask
   function automatic logic [7:0] exp_rate(input int cc, input int e);
      if (cc > e) return 8'h00;
      if (cc > e * 85 / 100) return 8'h80;
      return 8'hFF;
   endfunction
   task automatic report_and_stop;
      $display("comparisons %0d, mismatches %0d", cmp_count, fails);
      if (fails == 0 && cmp_count > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask
   //------------------------------------------------------------
   // Tests
   //------------------------------------------------------------
   initial begin
      void'($urandom(32'hE74C3837));
      repeat (3) @(posedge core_clk);
      rst <= 1'b0;
      for (int a = 0; a < 6; a++) begin
         rd(4'(a));
         chk(v, rv[a]);
      end
      rd(4'h8);
      chk(v, 16'h0000);
      $display("test reset done");
      wr(4'h0, 16'h0003);
      wr(4'h1, 16'h00C9);
      wr(4'h2, 16'h0065);
      rd(4'h7);
      chk(16'(v[0]), 16'h0001);
      for (int a = 0; a < 3; a++) begin
         rd(4'(a));
         chk(v, rv[a]);
      end
      wr(4'h1, 16'h00C8);
      rd(4'h1);
      chk(v, 16'h00C8);
      @(posedge core_clk) running <= 1'b1;
      wr(4'h1, 16'h0096);
      running <= 1'b0;
      rd(4'h1);
      chk(v, 16'h00C8);
      wr(4'h1, 16'h0096);
      $display("test settings done");
      accel_active <= 1'b1;
      for (int i = 0; i < 40; i++) begin
         c = (i < 4) ? corner[i] : $urandom_range(200, 100);
         drive(c, 0);
         chk(16'(ramp_rate), 16'(exp_rate(c, 150)));
         chk(16'(accel_hold), 16'(c > 150));
      end
      wr(4'h0, 16'h0000);
      drive(200, 0);
      chk(16'(ramp_rate), 16'h00FF);
      wr(4'h0, 16'h0002);
      drive(200, 0);
      chk(16'(rate_auto), 16'h0001);
      chk(16'(ramp_rate < 8'hFF), 16'h0001);
      wr(4'h0, 16'h0001);
      // Level 150 scaled by 6000/12000 gives 75; at 60000 it falls under the floor of 50
      out_freq <= 16'd12000;
      drive(76, 0);
      // Two full divides may pass before the new quotient shows
      repeat (60) @(posedge core_clk);
      rd(4'h7);
      chk(16'(v[15:8]), 16'd75);
      drive(76, 0);
      chk(16'(ramp_rate), 16'(exp_rate(76, 75)));
      out_freq <= 16'd60000;
      drive(0, 0);
      repeat (60) @(posedge core_clk);
      rd(4'h7);
      chk(16'(v[15:8]), 16'd50);
      $display("test accel done");
      accel_active <= 1'b0;
      decel_active <= 1'b1;
      out_freq <= 16'h0000;
      for (int i = 0; i < 11; i++) begin
         wr(4'h3, 16'(t[i][0]));
         wr(4'h6, 16'(t[i][1]));
         wr(4'h5, 16'(t[i][2]));
         drive(0, t[i][3]);
         chk(16'(decel_hold), 16'(t[i][4]));
         chk(16'(rate_auto), 16'(t[i][0] == 2));
         chk(16'(ramp_rate), t[i][4] ? 16'h0000 : 16'h00FF);
      end
      $display("test decel done");
      report_and_stop();
   end
   initial begin
      #100000;
      fails++;
      report_and_stop();
   end
endmodule
